// file: lgps_peer.sv
`timescale 1ns/1ps
`default_nettype none
module lgps_peer (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  probe_req,
    input  wire logic [15:0] probe_sig,
    input  wire logic [2:0]  probe_src,
    input  wire logic [7:0]  loop_mask,
    input  wire logic [2:0]  ret_off,
    output logic             probe_ack,
    output logic             rx_valid,
    output logic [15:0]      rx_sig,
    output logic [2:0]       rx_src,
    output logic [2:0]       rx_port
);
    initial begin
        {probe_ack, rx_valid, rx_sig, rx_src, rx_port} = '0;
    end
    always @(posedge sys_clk) begin
        probe_ack <= (probe_req != 8'h00) && !probe_ack;
        rx_valid  <= 1'b0;
        rx_sig    <= ~rx_sig;
        if ((probe_req != 8'h00) && !probe_ack && loop_mask[probe_src]) begin
            // Looped neighbour hands the probe back, offset by ret_off ports
            rx_valid <= 1'b1;
            rx_sig   <= probe_sig;
            rx_src   <= probe_src;
            rx_port  <= probe_src + ret_off;
        end
    end
endmodule : lgps_peer
`default_nettype wire

// file: lgps_pkg.sv
package lgps_pkg;
    localparam int unsigned NUM_PORTS    = 8;
    localparam int unsigned PORT_W       = 3;
    localparam int unsigned SIG_W        = 16;
    // Probe signature value is arbitrary
    localparam logic [15:0] PROBE_SIG    = 16'h5A3C;
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned PROBE_MS     = 1;
    localparam int unsigned PROBE_CYC    = (CLK_HZ / 1000) * PROBE_MS;
    localparam int unsigned TMR_W        = 24;
    localparam logic [7:0]  PORTS_RST    = 8'h00;
endpackage : lgps_pkg

// file: lgps_top.sv
`timescale 1ns/1ps
`default_nettype none
module lgps_top #(
    parameter int unsigned PROBE_PERIOD = lgps_pkg::PROBE_CYC
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic                        global_en,
    input  wire logic [lgps_pkg::NUM_PORTS-1:0] port_en,
    input  wire logic [lgps_pkg::NUM_PORTS-1:0] stp_en,
    input  wire logic [lgps_pkg::NUM_PORTS-1:0] reactivate,
    output logic [lgps_pkg::NUM_PORTS-1:0]   probe_req,
    output logic [lgps_pkg::SIG_W-1:0]       probe_sig,
    output logic [lgps_pkg::PORT_W-1:0]      probe_src,
    input  wire logic                        probe_ack,
    input  wire logic                        rx_valid,
    input  wire logic [lgps_pkg::SIG_W-1:0]  rx_sig,
    input  wire logic [lgps_pkg::PORT_W-1:0] rx_src,
    input  wire logic [lgps_pkg::PORT_W-1:0] rx_port,
    output logic [lgps_pkg::NUM_PORTS-1:0]   port_disabled,
    output logic                             shut_event,
    output logic [lgps_pkg::PORT_W-1:0]      shut_port
);
    localparam int unsigned N  = lgps_pkg::NUM_PORTS;
    localparam int unsigned PW = lgps_pkg::PORT_W;
    localparam int unsigned TW = lgps_pkg::TMR_W;

    typedef struct packed {
        logic [lgps_pkg::TMR_W-1:0]  tmr;
        logic [N-1:0]                pend;
        logic [N-1:0]                dis;
        logic                        evt;
        logic [lgps_pkg::PORT_W-1:0] evt_port;
    } lgps_state_t;

    lgps_state_t s_q;
    lgps_state_t s_d;
    logic [N-1:0] guard;
    logic [N-1:0] hit;
    logic [N-1:0] req;

    assign guard = port_en & ~stp_en & {N{global_en}} & ~s_q.dis;

    function automatic logic [lgps_pkg::PORT_W-1:0] lgps_first(input logic [N-1:0] v);
        lgps_first = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                lgps_first = i[lgps_pkg::PORT_W-1:0];
            end
        end
    endfunction : lgps_first

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_port
            // Own probe back on any port names its origin
            assign hit[g] = rx_valid && rx_sig == lgps_pkg::PROBE_SIG
                && rx_src == PW'(g) && guard[g];
        end
    endgenerate

    assign req = s_q.pend & guard;

    always_comb begin
        s_d     = s_q;
        s_d.evt = 1'b0;
        if (s_q.tmr == '0) begin
            s_d.tmr  = TW'(PROBE_PERIOD - 1);
            s_d.pend = guard;
        end else begin
            s_d.tmr = s_q.tmr - 1'b1;
        end
        if (probe_ack && req != '0) begin
            s_d.pend[lgps_first(req)] = 1'b0;
        end
        s_d.pend = s_d.pend & guard;
        s_d.dis  = s_q.dis & ~reactivate;
        if (hit != '0) begin
            s_d.dis[lgps_first(hit)] = 1'b1;
            s_d.evt                  = 1'b1;
            s_d.evt_port             = lgps_first(hit);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q          <= '0;
            s_q.dis      <= lgps_pkg::PORTS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign probe_req     = req != '0 ? (N'(1) << lgps_first(req)) : '0;
    assign probe_sig     = lgps_pkg::PROBE_SIG;
    assign probe_src     = lgps_first(req);
    assign port_disabled = s_q.dis;
    assign shut_event    = s_q.evt;
    assign shut_port     = s_q.evt_port;

    property p_shut_evt;
        @(posedge sys_clk) disable iff (!reset_n)
        (hit != '0) |=> shut_event && port_disabled[shut_port];
    endproperty
    a_shut_evt: assert property (p_shut_evt) else $error("Shutdown missed");

    property p_sticky;
        @(posedge sys_clk) disable iff (!reset_n)
        (port_disabled[0] && !reactivate[0]) |=> port_disabled[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Port re-enabled by itself");

    property p_stp_block;
        @(posedge sys_clk) disable iff (!reset_n)
        (probe_req & (stp_en | ~port_en | {N{~global_en}})) == '0;
    endproperty
    a_stp_block: assert property (p_stp_block) else $error("Probe on blocked port");

    property p_no_shut_off;
        @(posedge sys_clk) disable iff (!reset_n)
        !global_en |=> !shut_event;
    endproperty
    a_no_shut_off: assert property (p_no_shut_off) else $error("Shutdown while off");

    property p_port_off;
        @(posedge sys_clk) disable iff (!reset_n)
        (~port_en & ~port_disabled) != '0
            |=> (port_disabled & ~$past(port_disabled) & ~$past(port_en)) == '0;
    endproperty
    a_port_off: assert property (p_port_off) else $error("Disabled port shut");

    property p_same_port;
        @(posedge sys_clk) disable iff (!reset_n)
        (rx_valid && rx_sig == lgps_pkg::PROBE_SIG && rx_port == rx_src && guard[rx_src])
            |=> port_disabled[$past(rx_src)];
    endproperty
    a_same_port: assert property (p_same_port) else $error("Same port loop missed");

    property p_other_port;
        @(posedge sys_clk) disable iff (!reset_n)
        (rx_valid && rx_sig == lgps_pkg::PROBE_SIG && rx_port != rx_src && guard[rx_src])
            |=> port_disabled[$past(rx_src)] && shut_port == $past(rx_src);
    endproperty
    a_other_port: assert property (p_other_port) else $error("Remote loop missed");

    property p_probe;
        @(posedge sys_clk) disable iff (!reset_n)
        (s_q.tmr == '0 && guard[0]) |=> probe_req[0] || s_q.pend[0] || !guard[0];
    endproperty
    a_probe: assert property (p_probe) else $error("Probe not scheduled");

    property p_sig;
        @(posedge sys_clk) disable iff (!reset_n)
        (probe_req != '0) |-> probe_sig == lgps_pkg::PROBE_SIG;
    endproperty
    a_sig: assert property (p_sig) else $error("Bad probe signature");

    property p_evt_names_dis;
        @(posedge sys_clk) disable iff (!reset_n)
        shut_event |-> port_disabled[shut_port];
    endproperty
    a_evt_names_dis: assert property (p_evt_names_dis) else $error("Event on live port");

    property p_evt_port;
        @(posedge sys_clk) disable iff (!reset_n)
        (hit != '0) |=> shut_port == $past(rx_src);
    endproperty
    a_evt_port: assert property (p_evt_port) else $error("Event names wrong port");

    property p_evt_needs_hit;
        @(posedge sys_clk) disable iff (!reset_n)
        (hit == '0) |=> !shut_event;
    endproperty
    a_evt_needs_hit: assert property (p_evt_needs_hit) else $error("Event without loop");

    property p_new_dis_hit;
        @(posedge sys_clk) disable iff (!reset_n)
        (hit == '0) |=> (port_disabled & ~$past(port_disabled)) == '0;
    endproperty
    a_new_dis_hit: assert property (p_new_dis_hit) else $error("Port shut without loop");

    property p_react;
        @(posedge sys_clk) disable iff (!reset_n)
        (reactivate != '0 && hit == '0) |=> (port_disabled & $past(reactivate)) == '0;
    endproperty
    a_react: assert property (p_react) else $error("Reactivation ignored");

    property p_onehot;
        @(posedge sys_clk) disable iff (!reset_n)
        $onehot0(probe_req);
    endproperty
    a_onehot: assert property (p_onehot) else $error("Several probes at once");

    property p_src_match;
        @(posedge sys_clk) disable iff (!reset_n)
        (probe_req != '0) |-> probe_req[probe_src];
    endproperty
    a_src_match: assert property (p_src_match) else $error("Probe source mismatch");

    property p_dis_no_probe;
        @(posedge sys_clk) disable iff (!reset_n)
        (probe_req & port_disabled) == '0;
    endproperty
    a_dis_no_probe: assert property (p_dis_no_probe) else $error("Probe on shut port");

    property p_stp_no_shut;
        @(posedge sys_clk) disable iff (!reset_n)
        (stp_en != '0) |=> (port_disabled & ~$past(port_disabled) & $past(stp_en)) == '0;
    endproperty
    a_stp_no_shut: assert property (p_stp_no_shut) else $error("Shutdown under tree");

    property p_round;
        @(posedge sys_clk) disable iff (!reset_n)
        (s_q.tmr == '0) |=> s_q.tmr == TW'(PROBE_PERIOD - 1);
    endproperty
    a_round: assert property (p_round) else $error("Probe period wrong");
endmodule : lgps_top
`default_nettype wire

// file: test_loop_guard_port_shutdown.sv
`timescale 1ns/1ps
`default_nettype none
module test_loop_guard_port_shutdown;
    logic sys_clk, reset_n, global_en, probe_ack, rx_valid, shut_event;
    logic [7:0] port_en, stp_en, reactivate, probe_req, port_disabled, loop_mask;
    logic [15:0] probe_sig, rx_sig;
    logic [2:0] probe_src, rx_src, rx_port, shut_port, ret_off;
    int n_fail = 0, num_checks = 0, n_ev = 0;
    lgps_top #(.PROBE_PERIOD(16)) lgps_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .global_en(global_en), .port_en(port_en), .stp_en(stp_en), .reactivate(reactivate),
        .probe_req(probe_req), .probe_sig(probe_sig), .probe_src(probe_src),
        .probe_ack(probe_ack), .rx_valid(rx_valid), .rx_sig(rx_sig), .rx_src(rx_src),
        .rx_port(rx_port), .port_disabled(port_disabled), .shut_event(shut_event),
        .shut_port(shut_port));
    lgps_peer lgps_peer_inst (.sys_clk(sys_clk), .probe_req(probe_req), .probe_sig(probe_sig),
        .probe_src(probe_src), .loop_mask(loop_mask), .ret_off(ret_off), .probe_ack(probe_ack),
        .rx_valid(rx_valid), .rx_sig(rx_sig), .rx_src(rx_src), .rx_port(rx_port));
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (shut_event === 1'b1) n_ev++;
    task chk(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task run(input logic [7:0] pe, st, lm, input logic [2:0] off, input logic [7:0] ex, nev);
        @(posedge sys_clk);
        {port_en, stp_en, loop_mask, ret_off} <= {pe, st, lm, off};
        n_ev = 0;
        repeat (80) @(posedge sys_clk);
        #1 chk({8'h00, ex}, {8'h00, port_disabled});
        chk({8'h00, nev}, n_ev[15:0]);
    endtask : run
    task clr();
        @(posedge sys_clk);
        loop_mask <= 8'h00;
        repeat (2) @(posedge sys_clk);
        reactivate <= 8'hFF;
        @(posedge sys_clk);
        reactivate <= 8'h00;
        @(posedge sys_clk);
        #1 chk(16'h0000, {8'h00, port_disabled});
    endtask : clr
    task sc_same();
        run(8'hFF, 8'h00, 8'h24, 3'h0, 8'h24, 8'h02);
        chk(16'h0005, {13'h0000, shut_port});
        chk(lgps_pkg::PROBE_SIG, probe_sig);
        clr();
    endtask : sc_same
    task sc_other();
        run(8'hFF, 8'h00, 8'h80, 3'h3, 8'h80, 8'h01);
        clr();
    endtask : sc_other
    task sc_block();
        run(8'hF7, 8'h10, 8'hFF, 3'h1, 8'hE7, 8'h06);
        clr();
    endtask : sc_block
    task sc_global();
        @(posedge sys_clk);
        global_en <= 1'b0;
        run(8'hFF, 8'h00, 8'hFF, 3'h0, 8'h00, 8'h00);
        chk(16'h0000, {8'h00, probe_req});
        @(posedge sys_clk);
        global_en <= 1'b1;
        clr();
    endtask : sc_global
    task sc_hold();
        run(8'hFF, 8'h00, 8'h02, 3'h0, 8'h02, 8'h01);
        run(8'hFF, 8'h00, 8'h00, 3'h0, 8'h02, 8'h00);
        clr();
    endtask : sc_hold
    task wrap_up();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        {reset_n, global_en, port_en, stp_en, reactivate, loop_mask, ret_off} = '0;
        global_en = 1'b1;
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        sc_same();
        sc_other();
        sc_block();
        sc_global();
        sc_hold();
        wrap_up();
    end
    initial begin
        #(2000 * 50);
        n_fail++;
        wrap_up();
    end
endmodule : test_loop_guard_port_shutdown
`default_nettype wire
